// ==== core/swc_defs.vh ====
// Constants for the sleep and wake controller
`ifndef SWC_DEFS_VH
`define SWC_DEFS_VH

// Register byte offsets
`define SWC_OFF_CTRL      8'h00
`define SWC_OFF_IRQ_EN    8'h04
`define SWC_OFF_STATUS    8'h08
`define SWC_OFF_IRQ_PEND  8'h0c

// Control register fields
`define SWC_CTRL_GLB_EN   0
`define SWC_CTRL_T1_ASYNC 1
`define SWC_CTRL_ADC_RC   2
`define SWC_CTRL_RX_SLAVE 3
`define SWC_CTRL_SPT_SLV  4
`define SWC_CTRL_T1_OSC   5
`define SWC_CTRL_W        6
`define SWC_CTRL_RST      6'h00

// Interrupt enable register
`define SWC_IRQ_W         7
`define SWC_IRQ_EN_RST    7'h00

// Wake source positions in the interrupt vector
`define SWC_IRQ_TMR       0
`define SWC_IRQ_RX        1
`define SWC_IRQ_ADC       2
`define SWC_IRQ_IOC       3
`define SWC_IRQ_INT       4
`define SWC_IRQ_CAP       5
`define SWC_IRQ_SPT       6

// Status register fields
`define SWC_ST_TMO        0
`define SWC_ST_PWRDN      1
`define SWC_ST_SLEEP      2
`define SWC_ST_CAUSE_LO   4
`define SWC_ST_CAUSE_HI   5

// Flag reset values
`define SWC_TMO_RST       1'b1
`define SWC_PWRDN_RST     1'b1

// Wake cause codes
`define SWC_CAUSE_NONE    2'h0
`define SWC_CAUSE_PIN     2'h1
`define SWC_CAUSE_WDT     2'h2
`define SWC_CAUSE_IRQ     2'h3

// Program counter
`define SWC_PC_W          13
`define SWC_VECTOR        13'h0004
`define SWC_PC_RST        13'h0000

// Synchroniser reset value: pin high, oscillator ready, no flags
`define SWC_SYNC_RST      9'h180

`endif

// ==== core/swc_sync3.v ====
// Three stage input synchroniser with agreement filter
`timescale 1ns/100ps
`include "swc_defs.vh"
module swc_sync3 #(
  parameter       W   = 9,
  parameter [8:0] RST = `SWC_SYNC_RST
) (
  input  wire         mclk,
  input  wire         rstn,
  input  wire         ce,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout_q
);

  reg  [W-1:0] s1_q;
  reg  [W-1:0] s2_q;
  reg  [W-1:0] s3_q;
  wire [W-1:0] agree;
  wire [W-1:0] dout_d;

  // A bit only moves once the second and third stages agree on it
  assign agree  = ~(s2_q ^ s3_q);
  assign dout_d = (agree & s3_q) | (~agree & dout_q);

  always @(posedge mclk) begin
    if (!rstn) begin
      s1_q   <= RST[W-1:0];
      s2_q   <= RST[W-1:0];
      s3_q   <= RST[W-1:0];
      dout_q <= RST[W-1:0];
    end else if (ce) begin
      s1_q   <= din;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      dout_q <= dout_d;
    end
  end

endmodule

// ==== core/swc_ctrl.v ====
// Sleep entry and wake-up controller with APB register access
`timescale 1ns/100ps
`include "swc_defs.vh"

// Operation
// - Sleep clears the watchdog count; the watchdog keeps counting.
// - Sleep entry clears the power-down flag.
// - Sleep entry sets the timeout flag.
// - Main oscillator driver is off while asleep.
// - Timer oscillator enable is untouched by sleep.
// - Pins hold their pre-sleep drive: high, low or released.
// - A watchdog reset never drives the external reset pin low.
// - Wake on reset pin, enabled watchdog timeout, or qualifying interrupt.
// - Pin wake resets the device; watchdog and interrupt wakes resume.
// - Power-down flag set at power-up, cleared at every sleep.
// - Watchdog wake clears the timeout flag.
// - Only the seven listed interrupt sources can wake the device.
// - Timer wakes only in async mode; converter only on RC clock.
// - Sources needing on-chip clocks cannot raise wake interrupts.
// - Executing sleep prefetches the instruction at program counter plus one.
// - Enabled interrupt wakes regardless of the global enable.
// - Global enable clear: continue after the sleep instruction.
// - Global enable set: run next instruction, then vector to 0004h.
// - Already pending enabled interrupt: sleep completes, wake is immediate.
// - Watchdog and interrupt wakes clear the watchdog; a reset-pin wake does not.
module swc_ctrl (
  input  wire                   mclk,
  input  wire                   rstn,
  input  wire                   ce,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [7:0]             paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  // Processor core
  input  wire                   sleep_exec,
  input  wire [`SWC_PC_W-1:0]   program_counter,
  output reg                    prefetch_req,
  output reg  [`SWC_PC_W-1:0]   prefetch_addr,
  output wire                   core_run,
  output reg                    resume_pulse,
  output reg                    vector_req,
  output reg  [`SWC_PC_W-1:0]   vector_addr,
  output reg                    core_rst_n,
  // Watchdog
  input  wire                   wdt_enable,
  input  wire                   wdt_timeout,
  output reg                    wdt_clear,
  // Clocks
  output reg                    osc_drv_en,
  input  wire                   osc_ready,
  output wire                   t1_osc_en,
  // External reset pin, input only from this block's side
  input  wire                   external_reset_pin_n,
  output wire                   external_reset_pin_o,
  output wire                   external_reset_pin_oe,
  // Interrupt flags from peripherals
  input  wire [`SWC_IRQ_W-1:0]  irq_flags,
  // I/O pin drive, core side and pad side
  input  wire [7:0]             io_out_core,
  input  wire [7:0]             io_oe_core,
  output reg  [7:0]             io_out,
  output reg  [7:0]             io_oe,
  output wire                   io_frozen
);

  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_SLEEP = 2'b01;
  localparam [1:0] ST_WAKE  = 2'b10;

  reg  [1:0]             state_q;
  reg  [1:0]             state_d;
  reg  [`SWC_CTRL_W-1:0] ctrl_q;
  reg  [`SWC_IRQ_W-1:0]  irq_en_q;
  reg                    tmo_q;
  reg                    pwrdn_q;
  reg  [1:0]             cause_q;
  reg                    irq_wake_q;
  wire [8:0]             sync_in;
  wire [8:0]             sync_out;
  wire                   pin_low;
  wire                   osc_ok;
  wire [`SWC_IRQ_W-1:0]  flags_s;
  wire [`SWC_IRQ_W-1:0]  qual_now;
  wire                   irq_hit;
  wire                   wdt_hit;
  wire                   glb_irq_en;
  wire                   wr_en;
  wire                   rd_setup;
  wire                   mapped;

  // Only wake-capable sources pass: each masked by its enable, and
  // the mode-dependent ones by the mode that keeps them alive in sleep
  function [`SWC_IRQ_W-1:0] wake_srcs;
    input [`SWC_IRQ_W-1:0]  flags;
    input [`SWC_IRQ_W-1:0]  en;
    input [`SWC_CTRL_W-1:0] cfg;
    reg   [`SWC_IRQ_W-1:0]  live;
    begin
      live = {`SWC_IRQ_W{1'b1}};
      live[`SWC_IRQ_TMR] = cfg[`SWC_CTRL_T1_ASYNC];
      live[`SWC_IRQ_ADC] = cfg[`SWC_CTRL_ADC_RC];
      live[`SWC_IRQ_RX]  = cfg[`SWC_CTRL_RX_SLAVE];
      live[`SWC_IRQ_SPT] = cfg[`SWC_CTRL_SPT_SLV];
      wake_srcs = flags & en & live;
    end
  endfunction

  function addr_is;
    input [7:0] a;
    input [7:0] off;
    begin
      addr_is = (a[7:2] == off[7:2]);
    end
  endfunction

  // Pin-side inputs are asynchronous to mclk
  assign sync_in = {external_reset_pin_n, osc_ready, irq_flags};

  swc_sync3 #(
    .W   (9),
    .RST (`SWC_SYNC_RST)
  ) u_sync (
    .mclk   (mclk),
    .rstn   (rstn),
    .ce     (ce),
    .din    (sync_in),
    .dout_q (sync_out)
  );

  assign pin_low = ~sync_out[8];
  assign osc_ok  = sync_out[7];
  assign flags_s = sync_out[`SWC_IRQ_W-1:0];

  assign glb_irq_en = ctrl_q[`SWC_CTRL_GLB_EN];
  assign qual_now = wake_srcs(flags_s, irq_en_q, ctrl_q);
  // Global enable deliberately ignored here
  assign irq_hit  = |qual_now;
  assign wdt_hit  = wdt_enable & wdt_timeout;

  // The pin is only ever sensed; no reset path drives it
  assign external_reset_pin_o  = 1'b0;
  assign external_reset_pin_oe = 1'b0;

  // Timer oscillator follows software only, never the sleep state
  assign t1_osc_en = ctrl_q[`SWC_CTRL_T1_OSC];

  // Core stays stalled until the main clock is back, except after a reset-pin wake
  assign core_run  = (state_q == ST_RUN) & core_rst_n;
  assign io_frozen = (state_q != ST_RUN);

  // State machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        // A watchdog timeout in the same cycle wins and resets the core
        if (sleep_exec && !pin_low && !wdt_hit) begin
          if (irq_hit) begin
            state_d = ST_WAKE;
          end else begin
            state_d = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        // Reset pin assumed high here unless a reset is meant
        if (pin_low) begin
          state_d = ST_RUN;
        end else if (wdt_hit || irq_hit) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (pin_low) begin
          state_d = ST_RUN;
        end else if (osc_ok) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      state_q <= ST_RUN;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Flags, oscillator, watchdog and core handshake
  always @(posedge mclk) begin
    if (!rstn) begin
      tmo_q         <= `SWC_TMO_RST;
      pwrdn_q       <= `SWC_PWRDN_RST;
      cause_q       <= `SWC_CAUSE_NONE;
      irq_wake_q    <= 1'b0;
      osc_drv_en    <= 1'b1;
      wdt_clear     <= 1'b0;
      prefetch_req  <= 1'b0;
      prefetch_addr <= `SWC_PC_RST;
      resume_pulse  <= 1'b0;
      vector_req    <= 1'b0;
      vector_addr   <= `SWC_VECTOR;
      core_rst_n    <= 1'b0;
    end else if (ce) begin
      wdt_clear    <= 1'b0;
      prefetch_req <= 1'b0;
      resume_pulse <= 1'b0;
      vector_req   <= 1'b0;
      core_rst_n   <= ~pin_low;
      if (pin_low) begin
        // Full device reset; flags keep the cause for software
        osc_drv_en <= 1'b1;
        irq_wake_q <= 1'b0;
        if (state_q != ST_RUN) begin
          cause_q <= `SWC_CAUSE_PIN;
        end
      end else begin
        case (state_q)
          ST_RUN: begin
            if (wdt_hit) begin
              // Watchdog timeout while awake resets the core only
              core_rst_n <= 1'b0;
              tmo_q      <= 1'b0;
            end else if (sleep_exec) begin
              wdt_clear     <= 1'b1;
              pwrdn_q       <= 1'b0;
              tmo_q         <= 1'b1;
              prefetch_req  <= 1'b1;
              prefetch_addr <= program_counter + 13'h0001;
              cause_q       <= `SWC_CAUSE_NONE;
              irq_wake_q    <= irq_hit;
              // An already pending source keeps the clock alive
              osc_drv_en    <= irq_hit;
              if (irq_hit) begin
                cause_q <= `SWC_CAUSE_IRQ;
              end
            end
          end
          ST_SLEEP: begin
            if (wdt_hit) begin
              tmo_q      <= 1'b0;
              cause_q    <= `SWC_CAUSE_WDT;
              irq_wake_q <= 1'b0;
              osc_drv_en <= 1'b1;
            end else if (irq_hit) begin
              cause_q    <= `SWC_CAUSE_IRQ;
              irq_wake_q <= 1'b1;
              osc_drv_en <= 1'b1;
            end
          end
          ST_WAKE: begin
            osc_drv_en <= 1'b1;
            if (osc_ok) begin
              wdt_clear    <= 1'b1;
              resume_pulse <= 1'b1;
              // Core runs the prefetched word first, then vectors
              vector_req   <= irq_wake_q & glb_irq_en;
              vector_addr  <= `SWC_VECTOR;
              irq_wake_q   <= 1'b0;
            end
          end
          default: begin
            osc_drv_en <= 1'b1;
          end
        endcase
      end
    end
  end

  // Pad drive tracks the core while running and freezes otherwise
  always @(posedge mclk) begin
    if (!rstn) begin
      io_out <= 8'h00;
      io_oe  <= 8'h00;
    end else if (ce) begin
      if (state_q == ST_RUN && !(sleep_exec && !pin_low)) begin
        io_out <= io_out_core;
        io_oe  <= io_oe_core;
      end else if (state_q == ST_RUN) begin
        // Capture in the sleep cycle itself, so the last drive holds
        io_out <= io_out_core;
        io_oe  <= io_oe_core;
      end
    end
  end

  // APB slave: zero wait states, reads registered in the setup cycle
  assign pready   = 1'b1;
  assign mapped   = addr_is(paddr, `SWC_OFF_CTRL) ||
                    addr_is(paddr, `SWC_OFF_IRQ_EN) ||
                    addr_is(paddr, `SWC_OFF_STATUS) ||
                    addr_is(paddr, `SWC_OFF_IRQ_PEND);
  assign pslverr  = psel & penable & ~mapped;
  assign wr_en    = psel & penable & pwrite & ce;
  assign rd_setup = psel & ~penable & ~pwrite;

  always @(posedge mclk) begin
    if (!rstn) begin
      ctrl_q   <= `SWC_CTRL_RST;
      irq_en_q <= `SWC_IRQ_EN_RST;
    end else if (wr_en) begin
      if (addr_is(paddr, `SWC_OFF_CTRL)) begin
        ctrl_q <= pwdata[`SWC_CTRL_W-1:0];
      end else if (addr_is(paddr, `SWC_OFF_IRQ_EN)) begin
        irq_en_q <= pwdata[`SWC_IRQ_W-1:0];
      end
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (ce && rd_setup) begin
      prdata <= 32'h00000000;
      if (addr_is(paddr, `SWC_OFF_CTRL)) begin
        prdata[`SWC_CTRL_W-1:0] <= ctrl_q;
      end else if (addr_is(paddr, `SWC_OFF_IRQ_EN)) begin
        prdata[`SWC_IRQ_W-1:0] <= irq_en_q;
      end else if (addr_is(paddr, `SWC_OFF_STATUS)) begin
        prdata[`SWC_ST_TMO]   <= tmo_q;
        prdata[`SWC_ST_PWRDN] <= pwrdn_q;
        prdata[`SWC_ST_SLEEP] <= (state_q != ST_RUN);
        prdata[`SWC_ST_CAUSE_HI:`SWC_ST_CAUSE_LO] <= cause_q;
      end else if (addr_is(paddr, `SWC_OFF_IRQ_PEND)) begin
        prdata[`SWC_IRQ_W-1:0] <= qual_now;
      end
    end
  end

endmodule

// ==== sim/swc_ctrl_monitor.sv ====
// Port checks for the sleep and wake controller
`timescale 1ns/100ps
`include "swc_defs.vh"
module swc_ctrl_monitor (
  input wire        mclk,
  input wire        rstn,
  input wire [12:0] program_counter,
  input wire        prefetch_req,
  input wire [12:0] prefetch_addr,
  input wire        resume_pulse,
  input wire        vector_req,
  input wire [12:0] vector_addr,
  input wire        core_rst_n,
  input wire        core_run,
  input wire        wdt_clear,
  input wire        osc_drv_en,
  input wire        external_reset_pin_n,
  input wire        external_reset_pin_o,
  input wire        external_reset_pin_oe,
  input wire [7:0]  io_out,
  input wire [7:0]  io_oe,
  input wire        io_frozen
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  a_sleep_entry: assert property (
    $rose(io_frozen) |-> wdt_clear && prefetch_req)
    else $error("Sleep entry without clear or prefetch");
  a_prefetch_addr: assert property (
    prefetch_req |-> prefetch_addr == $past(program_counter) + 13'h1)
    else $error("Prefetch address wrong");
  a_osc_asleep: assert property (
    !osc_drv_en |-> io_frozen && !core_run)
    else $error("Oscillator off outside sleep");
  a_io_hold: assert property (
    $past(io_frozen) && io_frozen |-> $stable(io_out) && $stable(io_oe))
    else $error("Pin drive moved while frozen");
  a_pin_quiet: assert property (
    !external_reset_pin_oe && !external_reset_pin_o)
    else $error("Reset pin driven");
  a_pin_reset: assert property (
    !external_reset_pin_n [*7] |-> !core_rst_n)
    else $error("Reset pin low without core reset");
  a_wake_clear: assert property (
    resume_pulse |-> wdt_clear && core_run && core_rst_n)
    else $error("Resume without watchdog clear");
  a_vector_pulse: assert property (
    vector_req |-> resume_pulse && vector_addr == `SWC_VECTOR)
    else $error("Vector request wrong");

  cover property (vector_req);
  cover property (resume_pulse && !vector_req);
  cover property (!core_rst_n && !external_reset_pin_n);
endmodule

// ==== sim/swc_osc_model.sv ====
// Main oscillator: slow start after enable, stops at once
`timescale 1ns/100ps
module swc_osc_model #(
  parameter START = 12
) (
  input  wire mclk,
  input  wire osc_drv_en,
  output reg  osc_ready
);
  integer run_q = START;
  initial osc_ready = 1'b1;
  // Ready drops with the driver so no fetch can run on a dead clock
  always @(posedge mclk) begin
    if (!osc_drv_en) begin
      run_q <= 0;
      osc_ready <= 1'b0;
    end else begin
      if (run_q < START) run_q <= run_q + 1;
      osc_ready <= (run_q >= START - 1);
    end
  end
endmodule

// ==== sim/test_swc_ctrl.sv ====
// Self-checking bench for the sleep and wake controller
`timescale 1ns/100ps
`include "swc_defs.vh"
module test_swc_ctrl;
  reg         mclk = 1'b0, rstn = 1'b0, ce = 1'b1;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, rd;
  reg         sleep_exec = 1'b0, wdt_enable = 1'b0;
  reg         wdt_timeout = 1'b0, external_reset_pin_n = 1'b1, err;
  reg  [12:0] program_counter = 13'h0;
  reg  [6:0]  irq_flags = 7'h00;
  reg  [7:0]  io_out_core = 8'h00, io_oe_core = 8'h00;
  wire [31:0] prdata;
  wire        pready, pslverr, prefetch_req, core_run, resume_pulse;
  wire        vector_req, core_rst_n, wdt_clear, osc_drv_en, osc_ready;
  wire        t1_osc_en, external_reset_pin_o, external_reset_pin_oe;
  wire        io_frozen;
  wire [12:0] prefetch_addr, vector_addr;
  wire [7:0]  io_out, io_oe;
  integer     n_errors = 0, comparisons = 0, cycles = 0, i;

  swc_ctrl swc_ctrl_inst (
    .mclk                  (mclk),
    .rstn                  (rstn),
    .ce                    (ce),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .sleep_exec            (sleep_exec),
    .program_counter       (program_counter),
    .prefetch_req          (prefetch_req),
    .prefetch_addr         (prefetch_addr),
    .core_run              (core_run),
    .resume_pulse          (resume_pulse),
    .vector_req            (vector_req),
    .vector_addr           (vector_addr),
    .core_rst_n            (core_rst_n),
    .wdt_enable            (wdt_enable),
    .wdt_timeout           (wdt_timeout),
    .wdt_clear             (wdt_clear),
    .osc_drv_en            (osc_drv_en),
    .osc_ready             (osc_ready),
    .t1_osc_en             (t1_osc_en),
    .external_reset_pin_n  (external_reset_pin_n),
    .external_reset_pin_o  (external_reset_pin_o),
    .external_reset_pin_oe (external_reset_pin_oe),
    .irq_flags             (irq_flags),
    .io_out_core           (io_out_core),
    .io_oe_core            (io_oe_core),
    .io_out                (io_out),
    .io_oe                 (io_oe),
    .io_frozen             (io_frozen)
  );
  swc_osc_model #(
    .START (12)
  ) swc_osc_model_inst (
    .mclk       (mclk),
    .osc_drv_en (osc_drv_en),
    .osc_ready  (osc_ready)
  );

  always #12.5 mclk = ~mclk;

  task report_and_stop;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task go_sleep(input [12:0] pc, input osc_on);
    begin
      @(posedge mclk);
      // The modelled program keeps a no-operation after the sleep word
      sleep_exec <= 1'b1;
      program_counter <= pc;
      @(posedge mclk);
      sleep_exec <= 1'b0;
      @(negedge mclk);
      chk({prefetch_req, wdt_clear}, 2'b11);
      chk(prefetch_addr, pc + 13'h1);
      chk(osc_drv_en, osc_on);
    end
  endtask

  // Oscillator restart plus synchronisers take about 20 cycles
  task wait_resume;
    begin
      repeat (80) begin
        @(negedge mclk);
        if (resume_pulse === 1'b1) break;
      end
      chk({resume_pulse, core_rst_n}, 2'b11);
      chk(wdt_clear, 1'b1);
      chk(core_run, 1'b1);
    end
  endtask

  task t_reset;
    begin
      apb(1'b0, `SWC_OFF_STATUS, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, 8'h40, 32'hff);
      chk(err, 1'b1);
    end
  endtask

  task t_wdt;
    begin
      apb(1'b1, `SWC_OFF_CTRL, 32'h20);
      wdt_enable <= 1'b1;
      io_out_core <= 8'ha5;
      io_oe_core <= 8'h0f;
      go_sleep(13'h100, 1'b0);
      @(posedge mclk);
      io_out_core <= 8'h5a;
      io_oe_core <= 8'hf0;
      apb(1'b0, `SWC_OFF_STATUS, 32'h0);
      chk(rd & 32'h7, 32'h5);
      chk({io_oe, io_out}, 16'h0fa5);
      chk(t1_osc_en, 1'b1);
      chk(core_run, 1'b0);
      wdt_timeout <= 1'b1;
      @(posedge mclk);
      wdt_timeout <= 1'b0;
      wait_resume;
      chk(vector_req, 1'b0);
      apb(1'b0, `SWC_OFF_STATUS, 32'h0);
      chk(rd, 32'h20);
    end
  endtask

  task t_irq;
    for (i = 0; i < 7; i = i + 1) begin
      apb(1'b1, `SWC_OFF_CTRL, 32'h1e | (i & 1));
      apb(1'b1, `SWC_OFF_IRQ_EN, 32'h1 << i);
      go_sleep(13'h200 + i, 1'b0);
      @(posedge mclk);
      irq_flags <= 7'h1 << i;
      wait_resume;
      chk(vector_req, i & 1);
      apb(1'b0, `SWC_OFF_STATUS, 32'h0);
      chk(rd[5:4], 2'h3);
      irq_flags <= 7'h00;
      repeat (6) @(posedge mclk);
    end
  endtask

  task t_qual_pin;
    begin
      apb(1'b1, `SWC_OFF_CTRL, 32'h0);
      apb(1'b1, `SWC_OFF_IRQ_EN, 32'h5);
      irq_flags <= 7'h05;
      repeat (6) @(posedge mclk);
      apb(1'b0, `SWC_OFF_IRQ_PEND, 32'h0);
      chk(rd, 32'h0);
      go_sleep(13'h300, 1'b0);
      repeat (30) @(negedge mclk);
      chk(io_frozen, 1'b1);
      @(posedge mclk);
      // Pin is held high through sleep except for this deliberate wake
      external_reset_pin_n <= 1'b0;
      repeat (12) begin
        @(negedge mclk);
        if (core_rst_n === 1'b0) break;
      end
      chk(core_rst_n, 1'b0);
      @(posedge mclk);
      external_reset_pin_n <= 1'b1;
      irq_flags <= 7'h00;
      apb(1'b0, `SWC_OFF_STATUS, 32'h0);
      chk(rd[5:4], 2'h1);
    end
  endtask

  task t_immediate;
    begin
      apb(1'b1, `SWC_OFF_IRQ_EN, 32'h08);
      irq_flags <= 7'h08;
      repeat (6) @(posedge mclk);
      go_sleep(13'h400, 1'b1);
      wait_resume;
      chk(vector_req, 1'b0);
      @(posedge mclk);
      irq_flags <= 7'h00;
    end
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_wdt;
    t_irq;
    t_qual_pin;
    t_immediate;
    report_and_stop;
  end
endmodule

bind swc_ctrl swc_ctrl_monitor swc_ctrl_monitor_inst (
  .mclk                  (mclk),
  .rstn                  (rstn),
  .program_counter       (program_counter),
  .prefetch_req          (prefetch_req),
  .prefetch_addr         (prefetch_addr),
  .resume_pulse          (resume_pulse),
  .vector_req            (vector_req),
  .vector_addr           (vector_addr),
  .core_rst_n            (core_rst_n),
  .core_run              (core_run),
  .wdt_clear             (wdt_clear),
  .osc_drv_en            (osc_drv_en),
  .external_reset_pin_n  (external_reset_pin_n),
  .external_reset_pin_o  (external_reset_pin_o),
  .external_reset_pin_oe (external_reset_pin_oe),
  .io_out                (io_out),
  .io_oe                 (io_oe),
  .io_frozen             (io_frozen)
);
